// file: pkg/fbrg_pkg.sv
`default_nettype none

package fbrg_pkg;

    // ----------------------------------------------------------------
    // Bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;                 // Byte address width
    localparam int DATA_W = 32;                // Wishbone data width
    localparam int PAGE_MSB = 7;               // Page select field
    localparam int PAGE_LSB = 6;
    localparam int CH_MSB = 5;                 // Channel select field
    localparam int CH_LSB = 4;
    localparam int CH_W = 2;                   // Up to four channels
    localparam int OFF_MSB = 3;                // Register within channel
    localparam int BYTE_LANE = 0;              // All registers in lane 0

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [1:0] PAGE_CHAN = 2'h0;   // Per-channel registers
    localparam logic [1:0] PAGE_GLOB = 2'h1;   // Shared registers
    localparam logic [3:0] REG_DIV_LOW = 4'h0;
    localparam logic [3:0] REG_DIV_HIGH = 4'h4;
    localparam logic [3:0] REG_DIV_FRAC = 4'h8;
    localparam logic [3:0] REG_MODEM_CTRL = 4'hC;
    localparam logic [7:0] ADR_EIGHT_X = 8'h40;     // 8X select per channel
    localparam logic [7:0] ADR_STATUS = 8'h44;      // Bit-period toggles
    localparam logic [7:0] ADR_SOFT_RESET = 8'h48;  // Soft reset strobe

    // ----------------------------------------------------------------
    // Reset values and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] DIV_LOW_RST = 8'h01;
    localparam logic [7:0] DIV_HIGH_RST = 8'h00;
    localparam logic [3:0] DIV_FRAC_RST = 4'h0;
    localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
    localparam int MCR_PRESCALE_BIT = 7;       // Divide-by-4 prescaler
    localparam int SOFT_RESET_BIT = 0;
    localparam int FRAC_W = 4;                 // Implemented fraction bits

    // ----------------------------------------------------------------
    // Divider timing
    // ----------------------------------------------------------------
    localparam int ACC_W = 21;                 // Sixteenths accumulator
    localparam logic [1:0] PRESCALE_LAST = 2'h3;     // Divide by 4
    localparam logic [20:0] FRAC_ONE = 21'h000010;   // One in sixteenths
    localparam logic [3:0] BIT_LAST_16X = 4'hF;      // 16 samples a bit
    localparam logic [3:0] BIT_LAST_8X = 4'h7;       // 8 samples a bit
    localparam logic [3:0] BIT_MID_16X = 4'h7;       // 8th sample
    localparam logic [3:0] BIT_MID_8X = 4'h3;        // 4th sample

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    // Programmed divisor of one channel
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
        logic [FRAC_W-1:0] frac;
    } fbrg_div_s;

    // Timing strobes of one channel
    typedef struct packed {
        logic sample;      // 16X or 8X sampling clock enable
        logic bit_end;     // Last sample of a bit, transmit shift
        logic mid_bit;     // Centre of a bit, receive sample
    } fbrg_tick_s;

endpackage

`default_nettype wire

// file: rtl/fbrg_chan.sv
`timescale 1ns/100ps
`default_nettype none

module fbrg_chan (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // Channel control
    input wire logic prescale_sel,
    input wire logic eight_x,
    input wire fbrg_pkg::fbrg_div_s div,
    // Timing strobes
    output var fbrg_pkg::fbrg_tick_s tick
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] pre;                       // Prescaler phase
        logic [fbrg_pkg::ACC_W-1:0] acc;       // Divider phase
        logic [3:0] bcnt;                      // Sample within bit
        fbrg_pkg::fbrg_tick_s tick;            // Registered strobes
    } fbrg_chan_s;

    fbrg_chan_s q;
    fbrg_chan_s n;

    // Next state
    always_comb begin
        logic pre_tick;
        logic [fbrg_pkg::ACC_W-1:0] eff;
        logic [fbrg_pkg::ACC_W-1:0] dsum;
        logic [3:0] last;
        logic [3:0] mid;
        pre_tick = 1'b0;
        n = q;
        n.tick = '0;
        eff = {1'b0, div.high, div.low, div.frac};
        // A zero divisor behaves as one
        if (eff < fbrg_pkg::FRAC_ONE) begin
            eff = fbrg_pkg::FRAC_ONE;
        end
        dsum = q.acc + fbrg_pkg::FRAC_ONE;
        last = eight_x ? fbrg_pkg::BIT_LAST_8X : fbrg_pkg::BIT_LAST_16X;
        mid = eight_x ? fbrg_pkg::BIT_MID_8X : fbrg_pkg::BIT_MID_16X;
        if (ce) begin
            if (prescale_sel) begin
                if (q.pre == fbrg_pkg::PRESCALE_LAST) begin
                    n.pre = '0;
                    pre_tick = 1'b1;
                end else begin
                    n.pre = q.pre + 2'h1;
                end
            end else begin
                n.pre = '0;
                pre_tick = 1'b1;
            end
            if (pre_tick) begin
                if (dsum >= eff) begin
                    // A lowered divisor drops the excess phase at once,
                    // so no burst of back-to-back samples follows
                    if (q.acc >= eff) begin
                        n.acc = '0;
                    end else begin
                        n.acc = dsum - eff;
                    end
                    n.tick.sample = 1'b1;
                    n.tick.mid_bit = (q.bcnt == mid);
                    if (q.bcnt >= last) begin
                        n.bcnt = '0;
                        n.tick.bit_end = 1'b1;
                    end else begin
                        n.bcnt = q.bcnt + 4'h1;
                    end
                end else begin
                    n.acc = dsum;
                end
            end
        end else begin
            n.tick = q.tick;
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign tick = q.tick;

endmodule

`default_nettype wire

// file: rtl/fbrg_top.sv
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Each channel owns its generator and prescaler
// - Modem control bit 7 selects divide-by-4
// - Divide from one in sixteenth steps
// - Output is 16X or 8X sampling clock
// - Reset divisor low 0x01, others zero
// - Integer divisor is high byte, low byte
// - Fraction uses four low bits only
// - Rate is clock over divisor times 16/8
// - 8X odd fraction may jitter one sixteenth
// - Reference comes from oscillator core clock
// - Bit spans 16 or 8 samples

module fbrg_top #(
    parameter int NCH = 4                  // Channels, four at most
) (
    // Oscillator clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [fbrg_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [fbrg_pkg::DATA_W-1:0] wb_dat_i,
    output logic [fbrg_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Per-channel timing strobes
    output logic [NCH-1:0] sample_tick,
    output logic [NCH-1:0] bit_tick,
    output logic [NCH-1:0] mid_bit_tick
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ack;                             // Bus acknowledge
        logic [fbrg_pkg::DATA_W-1:0] rdat;     // Read data
        logic [NCH-1:0][7:0] div_low;          // divisor_low_byte
        logic [NCH-1:0][7:0] div_high;         // divisor_high_byte
        logic [NCH-1:0][3:0] div_frac;         // divisor_fraction
        logic [NCH-1:0][7:0] modem_ctrl;       // modem_control_reg
        logic [NCH-1:0] eight_x;               // eight_x_sampling_select
        logic [NCH-1:0] bit_tgl;               // Flips each bit period
    } fbrg_regs_s;

    fbrg_regs_s q;
    fbrg_regs_s n;

    // Channel strobes and divisors
    fbrg_pkg::fbrg_div_s [NCH-1:0] ch_div;
    fbrg_pkg::fbrg_tick_s [NCH-1:0] ch_tick;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic req;                                 // New request this cycle
    logic wr;                                  // Write with lane 0 on
    logic [1:0] page;                          // Register page
    logic [fbrg_pkg::CH_W-1:0] ch_idx;         // Addressed channel
    logic [3:0] reg_off;                       // Register in channel

    // Request is taken once, the cycle before ack
    assign req = wb_cyc_i & wb_stb_i & ~q.ack;
    assign wr = req & wb_we_i & wb_sel_i[fbrg_pkg::BYTE_LANE];
    assign page = wb_adr_i[fbrg_pkg::PAGE_MSB:fbrg_pkg::PAGE_LSB];
    assign ch_idx = wb_adr_i[fbrg_pkg::CH_MSB:fbrg_pkg::CH_LSB];
    assign reg_off = wb_adr_i[fbrg_pkg::OFF_MSB:0];

    // ----------------------------------------------------------------
    // Register next state
    // ----------------------------------------------------------------
    // Decodes one access, tracks bit periods, applies soft reset
    always_comb begin
        logic [fbrg_pkg::DATA_W-1:0] rd;
        logic soft_rst;
        rd = '0;
        soft_rst = 1'b0;
        n = q;
        if (ce) begin
            // Ack lasts one enabled cycle and freezes with ce low
            n.ack = 1'b0;
            // Status shows each channel stepping its bit periods
            for (int i = 0; i < NCH; i++) begin
                if (ch_tick[i].bit_end) begin
                    n.bit_tgl[i] = ~q.bit_tgl[i];
                end
            end
            // Per-channel registers
            for (int i = 0; i < NCH; i++) begin
                if (page == fbrg_pkg::PAGE_CHAN &&
                    ch_idx == fbrg_pkg::CH_W'(i)) begin
                    case (reg_off)
                        fbrg_pkg::REG_DIV_LOW: begin
                            rd = {24'h000000, q.div_low[i]};
                            if (wr) begin
                                n.div_low[i] = wb_dat_i[7:0];
                            end
                        end
                        fbrg_pkg::REG_DIV_HIGH: begin
                            rd = {24'h000000, q.div_high[i]};
                            if (wr) begin
                                n.div_high[i] = wb_dat_i[7:0];
                            end
                        end
                        fbrg_pkg::REG_DIV_FRAC: begin
                            rd = {28'h0000000, q.div_frac[i]};
                            if (wr) begin
                                n.div_frac[i] = wb_dat_i[3:0];
                            end
                        end
                        fbrg_pkg::REG_MODEM_CTRL: begin
                            rd = {24'h000000, q.modem_ctrl[i]};
                            if (wr) begin
                                n.modem_ctrl[i] = wb_dat_i[7:0];
                            end
                        end
                        // Unmapped offset reads zero
                        default: begin
                            rd = '0;
                        end
                    endcase
                end
            end
            // Shared registers
            if (page == fbrg_pkg::PAGE_GLOB) begin
                case (wb_adr_i)
                    fbrg_pkg::ADR_EIGHT_X: begin
                        rd = fbrg_pkg::DATA_W'(q.eight_x);
                        if (wr) begin
                            n.eight_x = wb_dat_i[NCH-1:0];
                        end
                    end
                    fbrg_pkg::ADR_STATUS: begin
                        rd = fbrg_pkg::DATA_W'(q.bit_tgl);
                    end
                    fbrg_pkg::ADR_SOFT_RESET: begin
                        // Write-only strobe, reads zero
                        soft_rst = wr & wb_dat_i[fbrg_pkg::SOFT_RESET_BIT];
                    end
                    // Unmapped address reads zero
                    default: begin
                        rd = '0;
                    end
                endcase
            end
            if (soft_rst) begin
                for (int i = 0; i < NCH; i++) begin
                    n.div_low[i] = fbrg_pkg::DIV_LOW_RST;
                    n.div_high[i] = fbrg_pkg::DIV_HIGH_RST;
                    n.div_frac[i] = fbrg_pkg::DIV_FRAC_RST;
                    n.modem_ctrl[i] = fbrg_pkg::MODEM_CTRL_RST;
                end
                n.eight_x = '0;
            end
            // Every access is answered one enabled cycle later
            if (req) begin
                n.ack = 1'b1;
                n.rdat = rd;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    // hardware reset gives divisor one
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q.ack <= 1'b0;
            q.rdat <= '0;
            q.div_low <= {NCH{fbrg_pkg::DIV_LOW_RST}};
            q.div_high <= {NCH{fbrg_pkg::DIV_HIGH_RST}};
            q.div_frac <= {NCH{fbrg_pkg::DIV_FRAC_RST}};
            q.modem_ctrl <= {NCH{fbrg_pkg::MODEM_CTRL_RST}};
            q.eight_x <= '0;
            q.bit_tgl <= '0;
        end else begin
            q <= n;
        end
    end

    // Bus outputs come straight from flip-flops
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;

    // ----------------------------------------------------------------
    // Sampling clock generators
    // ----------------------------------------------------------------
    // one generator per channel
    for (genvar g = 0; g < NCH; g++) begin : gen_chan
        // divisor carried as high, low, fraction
        assign ch_div[g] = '{
            high: q.div_high[g],
            low: q.div_low[g],
            frac: q.div_frac[g]
        };

        fbrg_chan u_chan (
            .core_clk(core_clk),
            .resetn(resetn),
            .ce(ce),
            .prescale_sel(q.modem_ctrl[g][fbrg_pkg::MCR_PRESCALE_BIT]),
            .eight_x(q.eight_x[g]),
            .div(ch_div[g]),
            .tick(ch_tick[g])
        );

        assign sample_tick[g] = ch_tick[g].sample;
        assign bit_tick[g] = ch_tick[g].bit_end;
        assign mid_bit_tick[g] = ch_tick[g].mid_bit;
    end

endmodule

`default_nettype wire

// file: test/fbrg_checker.sv
`timescale 1ns/100ps
`default_nettype none

module fbrg_checker #(
    parameter int NCH = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ce,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Strobes
    input wire logic [NCH-1:0] sample_tick,
    input wire logic [NCH-1:0] bit_tick,
    input wire logic [NCH-1:0] mid_bit_tick
);
    // ----------------------------------------------------------------
    // Helper state
    // ----------------------------------------------------------------
    logic ce_q;          // Outputs are fresh when set
    logic [7:0] span_q;  // Channel 0 samples since last bit end

    // Count fresh samples between bit ends
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ce_q <= 1'b0;
            span_q <= 8'h00;
        end else begin
            ce_q <= ce;
            if (ce_q && sample_tick[0]) begin
                span_q <= bit_tick[0] ? 8'h00 : span_q + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_follows: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_cause: assert property
        ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i && ce))
        else $error("ack without request");
    a_bit_on_sample: assert property ((bit_tick & ~sample_tick) == '0)
        else $error("bit end off a sample");
    a_mid_on_sample: assert property
        ((mid_bit_tick & ~sample_tick) == '0)
        else $error("mid bit off a sample");
    a_bit_span: assert property (ce_q && bit_tick[0] |-> span_q <= 8'h0F)
        else $error("bit longer than sixteen samples");
    a_freeze_ce: assert property
        (!ce |=> $stable({sample_tick, bit_tick, mid_bit_tick, wb_ack_o}))
        else $error("outputs moved with enable low");
    a_reset_quiet: assert property (@(posedge core_clk) disable iff (1'b0)
        !resetn |-> sample_tick == '0 && !wb_ack_o)
        else $error("outputs active in reset");
    a_upper_zero: assert property
        (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_unmapped_zero: assert property
        (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h80 |-> wb_dat_o == '0)
        else $error("unmapped read not zero");
endmodule

`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    localparam int NCH = 4;
    localparam int W = 4000;  // Tick counting window in cycles
    // ----------------------------------------------------------------
    // Signals and model
    // ----------------------------------------------------------------
    logic core_clk = 1'b0, resetn, ce = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o;
    logic [NCH-1:0] sample_tick, bit_tick, mid_bit_tick;
    int error_cnt = 0, cmp_count = 0, seed = 32'h642f968e;
    int s_cnt [NCH], b_cnt [NCH], m_cnt [NCH];
    bit counting = 1'b0;
    logic [7:0] mdl [256];  // Register model by address

    always #2.5 core_clk = ~core_clk;

    fbrg_top #(.NCH(NCH)) fbrg_top_inst (.core_clk(core_clk),
        .resetn(resetn), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sample_tick(sample_tick), .bit_tick(bit_tick),
        .mid_bit_tick(mid_bit_tick));

    // Strobe counters over the window
    always @(posedge core_clk) begin
        if (counting) begin
            for (int i = 0; i < NCH; i++) begin
                s_cnt[i] += sample_tick[i];
                b_cnt[i] += bit_tick[i];
                m_cnt[i] += mid_bit_tick[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check_val(input string nm, input logic [31:0] e,
                             input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic check_near(input string nm, input int e, input int s);
        cmp_count++;
        if (s < e - 1 || s > e + 1) begin
            error_cnt++;
            $display("FAIL %s expected %0d seen %0d", nm, e, s);
        end
    endtask

    // One classic cycle, held until ack is sampled
    task automatic wb_cycle(input logic we, input logic [7:0] a,
        input logic [7:0] d, input logic [3:0] s, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, 24'h0, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        if (n >= 50) check_val("ack", 32'h1, 32'h0);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask

    function automatic logic [7:0] wmask(input logic [7:0] a);
        if (a == 8'h40) return 8'h0F;
        if (a[7:4] >= 4'(NCH)) return 8'h00;
        case (a[3:0])
            4'h0, 4'h4, 4'hC: return 8'hFF;
            4'h8: return 8'h0F;
            default: return 8'h00;
        endcase
    endfunction

    function automatic void mdl_reset();
        foreach (mdl[i]) mdl[i] = 8'h00;
        for (int c = 0; c < NCH; c++) mdl[c*16] = 8'h01;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s);
        logic [31:0] rd;
        wb_cycle(1'b1, a, d, s, rd);
        if (a == 8'h48 && s[0] && d[0]) mdl_reset();
        else if (s[0]) mdl[a] = d & wmask(a);
    endtask

    task automatic read_all();
        logic [31:0] rd;
        for (int a = 0; a < 8'h84; a += 4) begin
            if (a < 8'h44 || a == 8'h4C || a == 8'h80) begin
                wb_cycle(1'b0, 8'(a), 8'h00, 4'hF, rd);
                check_val($sformatf("reg %h", a), {24'h0, mdl[a]}, rd);
            end
        end
    endtask

    task automatic rate_chk();
        int d16, sx;
        repeat (100) @(posedge core_clk);
        foreach (s_cnt[i]) {s_cnt[i], b_cnt[i], m_cnt[i]} = '0;
        counting <= 1'b1;
        repeat (W) @(posedge core_clk);
        counting <= 1'b0;
        @(posedge core_clk);
        for (int c = 0; c < NCH; c++) begin
            d16 = (mdl[c*16+4] * 256 + mdl[c*16]) * 16 + mdl[c*16+8];
            if (d16 < 16) d16 = 16;
            if (mdl[c*16+12][7]) d16 *= 4;
            sx = mdl[8'h40][c] ? 8 : 16;
            check_near("sample count", W * 16 / d16, s_cnt[c]);
            check_near("bit count", W * 16 / d16 / sx, b_cnt[c]);
            check_near("mid count", W * 16 / d16 / sx, m_cnt[c]);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] tl [4] = '{8'h01, 8'h03, 8'h02, 8'h06};
        logic [7:0] tf [4] = '{8'h00, 8'h08, 8'h01, 8'h0B};
        // A real falling edge so the asynchronous reset takes hold
        resetn <= 1'b0;
        mdl_reset();
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        read_all();
        $display("test reset_values done");
        for (int a = 0; a < 8'h44; a += 4) wr(8'(a), 8'($random(seed)), 4'h1);
        wr(8'h80, 8'hFF, 4'h1);
        wr(8'h00, 8'h55, 4'h0);
        read_all();
        $display("test readback done");
        wr(8'h48, 8'h01, 4'h1);
        read_all();
        $display("test soft_reset done");
        for (int c = 0; c < NCH; c++) begin
            wr(8'(c*16), tl[c], 4'h1);
            wr(8'(c*16+8), tf[c], 4'h1);
            wr(8'(c*16+12), (c == 2) ? 8'h80 : 8'h00, 4'h1);
        end
        wr(8'h40, 8'h0A, 4'h1);
        rate_chk();
        $display("test fixed_rates done");
        repeat (2) begin
            for (int c = 0; c < NCH; c++) begin
                wr(8'(c*16), 8'($random(seed)) & 8'h1F | 8'h01, 4'h1);
                wr(8'(c*16+8), 8'($random(seed)), 4'h1);
                wr(8'(c*16+12), 8'($random(seed)), 4'h1);
            end
            wr(8'h40, 8'($random(seed)), 4'h1);
            rate_chk();
        end
        $display("test random_rates done");
        ce <= 1'b0;
        repeat (20) @(posedge core_clk);
        ce <= 1'b1;
        resetn <= 1'b0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        mdl_reset();
        read_all();
        $display("test freeze_and_reset done");
        wrap_up();
    end

    // Hang guard
    initial begin
        repeat (40000) @(posedge core_clk);
        error_cnt++;
        wrap_up();
    end
endmodule

bind fbrg_top fbrg_checker #(.NCH(NCH)) fbrg_checker_inst (
    .core_clk(core_clk), .resetn(resetn), .ce(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_tick(sample_tick),
    .bit_tick(bit_tick), .mid_bit_tick(mid_bit_tick));

`default_nettype wire
